/* design/rcm_apb_if.sv */
`timescale 1ns/1ps
`include "rcm_cfg.svh"
// APB slave front end: one-cycle answer, strobes out
module rcm_apb_if (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  output logic             pready,
  output logic             pslverr,
  output logic             wr_stb,
  output logic             rd_stb
);
  typedef struct packed {
    logic unused;
  } rcm_apb_s;
  rcm_apb_s st_q, st_d;

  // Zero wait states; unmapped reads give zero
  always_comb begin
    st_d   = st_q;
    wr_stb = psel && penable && pwrite;
    rd_stb = psel && penable && !pwrite;
    pready = psel && penable;
    pslverr = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule // rcm_apb_if

/* design/rcm_ctrl.sv */
`timescale 1ns/1ps
`include "rcm_cfg.svh"
// Behaviour
// [RULE1] Control modes configurable anytime after multichip sync completes.
// [RULE2] Transmit SPI mode puts masked channels under register enable control.
// [RULE3] Transmit pin-mode write leaves masked channels' current mode unchanged.
// [RULE4] Invalid transmit mode leaves masked channels with no control mode.
// [RULE5] Transmit mask is four bits, bit0 is channel 1; 15 means all.
// [RULE6] Receive mode is SPI, pin, or invalid retaining current mode.
// [RULE7] Invalid receive mode is a no-op for masked channels.
// [RULE8] Receive mask is four bits, bit0 channel 1; 15 means all.
// [RULE9] Observation SPI mode enables paths from register, ignoring pins.
// [RULE10] Single-channel modes use one, two or three control pins.
// [RULE11] Dual-channel modes with four or two pins enable two paths.
// [RULE12] Invalid observation mode leaves current mode unchanged.
// [RULE13] Wait 2 to 18 cycles (field 0..16) before sampling select pins.
// [RULE14] One-pin mode field picks which path the single pin enables.
// [RULE15] Invalid one-pin path choice keeps the previous selection.
// [RULE16] Two-pin: A enables selected path, B picks one of two.
// [RULE17] Three-pin: A enables; C,B select paths 1 to 4.
// [RULE18] Dual four-pin: A,C enable; B,D choose path per enable.
// [RULE19] Channels with clear mask bit keep existing control mode.
module rcm_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        multichip_sync_done,
  input  wire logic [3:0]  tx_pin_en,
  input  wire logic [3:0]  rx_pin_en,
  input  wire logic        obs_enable_pin_a,
  input  wire logic        obs_select_pin_b,
  input  wire logic        obs_ctrl_pin_c,
  input  wire logic        obs_select_pin_d,
  output logic      [3:0]  tx_path_en,
  output logic      [3:0]  rx_path_en,
  output logic      [3:0]  obs_path_en
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rcm_pkg::rcm_src_e [3:0] tx_src;
    rcm_pkg::rcm_src_e [3:0] rx_src;
    logic [3:0]              tx_spi_en;
    logic [3:0]              rx_spi_en;
    logic [3:0]              obs_spi_en;
    logic [2:0]              obs_mode;
    logic [4:0]              dly;
    logic [1:0]              sel1;
    logic [1:0]              sel2_lo;
    logic [1:0]              sel2_hi;
    logic [1:0]              dual;
    rcm_pkg::rcm_state_e     fsm;
    logic [4:0]              cnt;
    logic [3:0]              pins_seen;
    logic [3:0]              pins;
    logic [3:0]              tx_out;
    logic [3:0]              rx_out;
    logic [3:0]              obs_out;
    logic [31:0]             rdata;
  } rcm_ctrl_s;
  rcm_ctrl_s st_q, st_d;

  logic       wr_stb;
  logic       rd_stb;
  logic [3:0] dec_en;
  logic [3:0] pins_now;
  logic [3:0] tmask;
  logic [3:0] rmask;

  assign pins_now = {obs_select_pin_d, obs_ctrl_pin_c, obs_select_pin_b, obs_enable_pin_a};
  assign tmask    = pwdata[`RCM_MASK_LSB +: 4];
  assign rmask    = pwdata[`RCM_MASK_LSB +: 4];

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  rcm_apb_if u_apb (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pready  (pready),
    .pslverr (pslverr),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb)
  );

  rcm_obs_dec u_dec (
    .mode    (st_q.obs_mode),
    .pins    (st_q.pins),
    .sel1    (st_q.sel1),
    .sel2_lo (st_q.sel2_lo),
    .sel2_hi (st_q.sel2_hi),
    .dual    (st_q.dual),
    .path_en (dec_en)
  );

  // Pick enable by source of a channel
  function automatic logic pick(input rcm_pkg::rcm_src_e s, input logic spi, input logic pin);
    case (s)
      rcm_pkg::RCM_SRC_SPI: pick = spi;
      rcm_pkg::RCM_SRC_PIN: pick = pin;
      default:              pick = 1'b0;
    endcase
  endfunction

  // Selection field update; invalid code keeps old
  function automatic logic [1:0] upd_sel(input logic [2:0] code, input logic [1:0] old);
    upd_sel = (code < `RCM_SEL_INVALID) ? code[1:0] : old;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // [RULE1] config gated by sync
    if (wr_stb && multichip_sync_done) begin
      if (paddr == `RCM_OFF_TXCFG) begin
        for (int i = 0; i < 4; i++) begin
          // [RULE5] mask bit per channel
          if (tmask[i]) begin
            // [RULE2] SPI takes control
            if (pwdata[1:0] == `RCM_TX_SPI) begin
              st_d.tx_src[i] = rcm_pkg::RCM_SRC_SPI;
            // [RULE3] pin value keeps mode
            end else if (pwdata[1:0] == `RCM_TX_PIN) begin
              st_d.tx_src[i] = st_q.tx_src[i];
            // [RULE4] invalid clears mode
            end else begin
              st_d.tx_src[i] = rcm_pkg::RCM_SRC_NONE;
            end
          end
          // [RULE19] unmasked untouched
        end
        st_d.tx_spi_en = pwdata[11:8];
      end else if (paddr == `RCM_OFF_RXCFG) begin
        for (int i = 0; i < 4; i++) begin
          // [RULE8] mask bit per channel
          if (rmask[i]) begin
            // [RULE6] three behaviours
            if (pwdata[1:0] == `RCM_RX_SPI) begin
              st_d.rx_src[i] = rcm_pkg::RCM_SRC_SPI;
            end else if (pwdata[1:0] == `RCM_RX_PIN) begin
              st_d.rx_src[i] = rcm_pkg::RCM_SRC_PIN;
            end
            // [RULE7] invalid is no-op
          end
        end
        st_d.rx_spi_en = pwdata[11:8];
      end else if (paddr == `RCM_OFF_ORXCFG) begin
        // [RULE12] invalid mode ignored
        if (pwdata[2:0] <= `RCM_ORX_D2) begin
          st_d.obs_mode = pwdata[2:0];
        end
        // [RULE13] out-of-range delay field ignored, old value kept
        if (pwdata[8:4] <= `RCM_DLY_MAX) begin
          st_d.dly = pwdata[8:4];
        end
        // [RULE9] register path enables
        st_d.obs_spi_en = pwdata[15:12];
      end else if (paddr == `RCM_OFF_ORXSEL) begin
        // [RULE15] invalid choice kept
        st_d.sel1    = upd_sel(pwdata[`RCM_SEL1_LSB +: 3], st_q.sel1);
        st_d.sel2_lo = upd_sel(pwdata[`RCM_SEL2L_LSB +: 3], st_q.sel2_lo);
        st_d.sel2_hi = upd_sel(pwdata[`RCM_SEL2H_LSB +: 3], st_q.sel2_hi);
        st_d.dual    = (pwdata[`RCM_DUAL_LSB +: 3] < `RCM_DUAL_INVALID)
                     ? pwdata[`RCM_DUAL_LSB +: 2] : st_q.dual;
      end
    end
    // [RULE13] settle then sample
    case (st_q.fsm)
      rcm_pkg::RCM_IDLE: begin
        if (pins_now != st_q.pins_seen) begin
          st_d.pins_seen = pins_now;
          st_d.cnt       = st_q.dly + `RCM_DLY_BASE - 5'h01;
          st_d.fsm       = rcm_pkg::RCM_SETTLE;
        end
      end
      rcm_pkg::RCM_SETTLE: begin
        if (st_q.cnt == 5'h01) begin
          st_d.fsm = rcm_pkg::RCM_SAMPLE;
        end else begin
          st_d.cnt = st_q.cnt - 5'h01;
        end
      end
      rcm_pkg::RCM_SAMPLE: begin
        st_d.pins      = pins_now;
        st_d.pins_seen = pins_now;
        st_d.fsm       = rcm_pkg::RCM_IDLE;
      end
      default: st_d.fsm = rcm_pkg::RCM_IDLE;
    endcase
    // Outputs registered
    for (int i = 0; i < 4; i++) begin
      st_d.tx_out[i] = pick(st_q.tx_src[i], st_q.tx_spi_en[i], tx_pin_en[i]);
      st_d.rx_out[i] = pick(st_q.rx_src[i], st_q.rx_spi_en[i], rx_pin_en[i]);
    end
    // [RULE10] pin modes via decoder
    st_d.obs_out = (st_q.obs_mode == `RCM_ORX_SPI) ? st_q.obs_spi_en : dec_en;
    // Read mux
    st_d.rdata = 32'h0000_0000;
    if (paddr == `RCM_OFF_ORXCFG) begin
      st_d.rdata = {16'h0000, st_q.obs_spi_en, 3'h0, st_q.dly, 1'b0, st_q.obs_mode};
    end else if (paddr == `RCM_OFF_ORXSEL) begin
      st_d.rdata = {18'h0, st_q.dual, 2'h0, st_q.sel2_hi, 2'h0, st_q.sel2_lo, 2'h0, st_q.sel1};
    end else if (paddr == `RCM_OFF_TXCFG) begin
      st_d.rdata = {20'h0, st_q.tx_spi_en, st_q.tx_src};
    end else if (paddr == `RCM_OFF_RXCFG) begin
      st_d.rdata = {20'h0, st_q.rx_spi_en, st_q.rx_src};
    end else if (paddr == `RCM_OFF_STATUS) begin
      st_d.rdata = {23'h0, st_q.pins, st_q.obs_out, st_q.fsm != rcm_pkg::RCM_IDLE};
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Read data comb from registers; one-cycle access phase
  assign prdata      = rd_stb ? st_q.rdata : 32'h0000_0000;
  assign tx_path_en  = st_q.tx_out;
  assign rx_path_en  = st_q.rx_out;
  assign obs_path_en = st_q.obs_out;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_txw(logic [1:0] m);
    wr_stb && multichip_sync_done && paddr == `RCM_OFF_TXCFG && pwdata[1:0] == m;
  endsequence

  a_tx_spi_take: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    s_txw(`RCM_TX_SPI) ##0 pwdata[4] |=> st_q.tx_src[0] == rcm_pkg::RCM_SRC_SPI)
    else $error("tx spi mode not taken");
  a_tx_pin_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
    s_txw(`RCM_TX_PIN) |=> $stable(st_q.tx_src))
    else $error("tx pin write changed mode");
  a_tx_inv_none: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    s_txw(2'h2) ##0 pwdata[4] |=> st_q.tx_src[0] == rcm_pkg::RCM_SRC_NONE)
    else $error("tx invalid did not clear");
  a_tx_unmask: assert property (@(posedge pclk) disable iff (!presetn) // [RULE19]
    s_txw(`RCM_TX_SPI) ##0 !pwdata[5] |=> $stable(st_q.tx_src[1]))
    else $error("unmasked tx changed");
  a_rx_inv_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    wr_stb && multichip_sync_done && paddr == `RCM_OFF_RXCFG && pwdata[1:0] > 2'h1
    |=> $stable(st_q.rx_src))
    else $error("rx invalid changed mode");
  a_orx_inv_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    wr_stb && multichip_sync_done && paddr == `RCM_OFF_ORXCFG && pwdata[2:0] > 3'h5
    |=> $stable(st_q.obs_mode))
    else $error("obs invalid changed mode");
  a_settle_min: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    st_q.fsm == rcm_pkg::RCM_IDLE ##1 st_q.fsm == rcm_pkg::RCM_SETTLE
    |-> st_q.cnt == $past(st_q.dly) + `RCM_DLY_BASE - 5'h01)
    else $error("settle count wrong");
  a_presync_lock: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    wr_stb && !multichip_sync_done |=> $stable(st_q.obs_mode) && $stable(st_q.tx_src))
    else $error("config taken before sync");
  a_spi_obs: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    st_q.obs_mode == `RCM_ORX_SPI && $stable(st_q.obs_mode) |=> obs_path_en == $past(st_q.obs_spi_en))
    else $error("obs spi enable mismatch");

  // ----------------------------------------------------------------
  // Assertions: transmit and receive sources
  // ----------------------------------------------------------------
  sequence s_rxw(logic [1:0] m);
    wr_stb && multichip_sync_done && paddr == `RCM_OFF_RXCFG && pwdata[1:0] == m;
  endsequence

  a_rx_spi_take: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    s_rxw(`RCM_RX_SPI) ##0 pwdata[7] |=> st_q.rx_src[3] == rcm_pkg::RCM_SRC_SPI)
    else $error("rx spi mode not taken");
  a_rx_pin_take: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    s_rxw(`RCM_RX_PIN) ##0 pwdata[4] |=> st_q.rx_src[0] == rcm_pkg::RCM_SRC_PIN)
    else $error("rx pin mode not taken");
  a_rx_unmask: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    s_rxw(`RCM_RX_SPI) ##0 !pwdata[4] |=> $stable(st_q.rx_src[0]))
    else $error("unmasked rx changed");
  a_tx_mask_all: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    s_txw(`RCM_TX_SPI) ##0 pwdata[7:4] == 4'hF
    |=> st_q.tx_src[3] == rcm_pkg::RCM_SRC_SPI && st_q.tx_src[1] == rcm_pkg::RCM_SRC_SPI)
    else $error("full tx mask missed a channel");
  a_tx_out_spi: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    st_q.tx_src[2] == rcm_pkg::RCM_SRC_SPI |=> tx_path_en[2] == $past(st_q.tx_spi_en[2]))
    else $error("tx spi enable not followed");
  a_tx_none_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    st_q.tx_src[0] == rcm_pkg::RCM_SRC_NONE |=> !tx_path_en[0])
    else $error("tx path on with no mode");
  a_rx_out_pin: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    st_q.rx_src[1] == rcm_pkg::RCM_SRC_PIN |=> rx_path_en[1] == $past(rx_pin_en[1]))
    else $error("rx pin enable not followed");

  // ----------------------------------------------------------------
  // Assertions: observation pins and settling
  // ----------------------------------------------------------------
  // Latched pins may move only in the sample step, never mid-settle
  sequence s_settle_done;
    st_q.fsm == rcm_pkg::RCM_SETTLE ##1 st_q.fsm == rcm_pkg::RCM_SAMPLE;
  endsequence
  sequence s_selw;
    wr_stb && multichip_sync_done && paddr == `RCM_OFF_ORXSEL;
  endsequence

  a_settle_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    st_q.fsm != rcm_pkg::RCM_SAMPLE |=> $stable(st_q.pins))
    else $error("pins latched outside sample step");
  a_sample_pins: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    s_settle_done |=> st_q.pins == $past(pins_now))
    else $error("pins not sampled after settling");
  a_sel_inv_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    s_selw ##0 pwdata[`RCM_SEL1_LSB +: 3] >= `RCM_SEL_INVALID |=> $stable(st_q.sel1))
    else $error("invalid one-pin choice applied");
  a_one_pin_path: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    st_q.obs_mode == `RCM_ORX_S1 && st_q.pins[0]
    |=> obs_path_en == (4'h1 << $past(st_q.sel1)))
    else $error("one-pin path wrong");
  a_two_pin_off: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    st_q.obs_mode == `RCM_ORX_S2 && !st_q.pins[0] |=> obs_path_en == 4'h0)
    else $error("two-pin mode path on with enable low");
  a_three_pin_path: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    st_q.obs_mode == `RCM_ORX_S3 && st_q.pins[0]
    |=> obs_path_en == (4'h1 << $past(st_q.pins[2:1])))
    else $error("three-pin path wrong");
  a_dual_pair: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    st_q.obs_mode == `RCM_ORX_D2 && st_q.pins[0] && st_q.pins[2] |=> $countones(obs_path_en) == 2)
    else $error("dual two-pin did not enable two paths");
  a_four_pin_pair: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
    st_q.obs_mode == `RCM_ORX_D4 && st_q.pins[0] && st_q.pins[2] |=> $countones(obs_path_en) == 2)
    else $error("dual four-pin did not enable two paths");
endmodule // rcm_ctrl

/* design/rcm_obs_dec.sv */
`timescale 1ns/1ps
`include "rcm_cfg.svh"
// Pin decoder for observation path enables (pure function of mode, selection fields and latched pins)
module rcm_obs_dec (
  input  wire logic [2:0] mode,
  input  wire logic [3:0] pins,
  input  wire logic [1:0] sel1,
  input  wire logic [1:0] sel2_lo,
  input  wire logic [1:0] sel2_hi,
  input  wire logic [1:0] dual,
  output logic      [3:0] path_en
);
  function automatic logic [3:0] onehot(input logic [1:0] i);
    onehot = 4'h1 << i;
  endfunction

  // Pins: [0]=A enable, [1]=B select, [2]=C, [3]=D select
  always_comb begin
    path_en = 4'h0;
    case (mode)
      // [RULE14] one pin chosen path
      `RCM_ORX_S1: if (pins[0]) path_en = onehot(sel1);
      // [RULE16] A enables, B picks
      `RCM_ORX_S2: if (pins[0]) path_en = onehot(pins[1] ? sel2_hi : sel2_lo);
      // [RULE17] C,B encode path
      `RCM_ORX_S3: if (pins[0]) path_en = onehot({pins[2], pins[1]});
      // [RULE18] A/C enable, B/D pick
      `RCM_ORX_D4: path_en = (pins[0] ? (pins[1] ? 4'h2 : 4'h1) : 4'h0)
                           | (pins[2] ? (pins[3] ? 4'h8 : 4'h4) : 4'h0);
      // [RULE11] dual two pin pairs
      `RCM_ORX_D2: path_en = (pins[0] ? onehot({1'b0, dual[1]}) : 4'h0)
                           | (pins[2] ? onehot({1'b1, dual[0]}) : 4'h0);
      default: path_en = 4'h0;
    endcase
  end
endmodule // rcm_obs_dec

/* pkg/rcm_cfg.svh */
`ifndef RCM_CFG_SVH
`define RCM_CFG_SVH
// Register byte offsets
`define RCM_OFF_TXCFG   12'h000
`define RCM_OFF_RXCFG   12'h004
`define RCM_OFF_ORXCFG  12'h008
`define RCM_OFF_ORXSEL  12'h00C
`define RCM_OFF_CTRL    12'h010
`define RCM_OFF_STATUS  12'h014
// Field positions
`define RCM_MODE_LSB    0
`define RCM_MASK_LSB    4
`define RCM_DLY_LSB     4
`define RCM_SEL1_LSB    0
`define RCM_SEL2L_LSB   4
`define RCM_SEL2H_LSB   8
`define RCM_DUAL_LSB    12
// Mode encodings
`define RCM_TX_SPI      2'h0
`define RCM_TX_PIN      2'h1
`define RCM_RX_SPI      2'h0
`define RCM_RX_PIN      2'h1
`define RCM_ORX_SPI     3'h0
`define RCM_ORX_S3      3'h1
`define RCM_ORX_S2      3'h2
`define RCM_ORX_S1      3'h3
`define RCM_ORX_D4      3'h4
`define RCM_ORX_D2      3'h5
// Settling delay: field 0..16 gives 2..18 cycles
`define RCM_DLY_MAX     5'h10
`define RCM_DLY_BASE    5'h02
`define RCM_SEL_INVALID 3'h4
`define RCM_DUAL_INVALID 3'h4
`endif

/* pkg/rcm_pkg.sv */
package rcm_pkg;
  // Per-channel control source
  typedef enum logic [1:0] {RCM_SRC_NONE, RCM_SRC_SPI, RCM_SRC_PIN} rcm_src_e;
  typedef enum logic [1:0] {RCM_IDLE, RCM_SETTLE, RCM_SAMPLE} rcm_state_e;
endpackage

/* testbench/rcm_bb_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Baseband side driving enable and select pins
// ----------------------------------------
module rcm_bb_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] obs_req,
  input  wire logic [3:0] tx_req,
  input  wire logic [3:0] rx_req,
  output logic      [3:0] tx_pin_en,
  output logic      [3:0] rx_pin_en,
  output logic            obs_enable_pin_a,
  output logic            obs_select_pin_b,
  output logic            obs_ctrl_pin_c,
  output logic            obs_select_pin_d
);
  // Pins move only just after an edge, so settling sees steady levels
  // pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_en <= 4'h0;
      rx_pin_en <= 4'h0;
      {obs_select_pin_d, obs_ctrl_pin_c, obs_select_pin_b, obs_enable_pin_a} <= 4'h0;
    end else begin
      tx_pin_en <= tx_req;
      rx_pin_en <= rx_req;
      {obs_select_pin_d, obs_ctrl_pin_c, obs_select_pin_b, obs_enable_pin_a} <= obs_req;
    end
  end
endmodule // rcm_bb_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`include "rcm_cfg.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_done;
  logic        pa, pb, pc, pd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  tx_pin, rx_pin, tx_en, rx_en, obs_en, obs_req, tx_req, rx_req;
  int          bad_count, checks_done, cyc;

  rcm_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .multichip_sync_done(sync_done), .tx_pin_en(tx_pin),
    .rx_pin_en(rx_pin), .obs_enable_pin_a(pa), .obs_select_pin_b(pb),
    .obs_ctrl_pin_c(pc), .obs_select_pin_d(pd), .tx_path_en(tx_en),
    .rx_path_en(rx_en), .obs_path_en(obs_en));
  rcm_bb_model bb (.pclk(pclk), .presetn(presetn), .obs_req(obs_req), .tx_req(tx_req),
    .rx_req(rx_req), .tx_pin_en(tx_pin), .rx_pin_en(rx_pin), .obs_enable_pin_a(pa),
    .obs_select_pin_b(pb), .obs_ctrl_pin_c(pc), .obs_select_pin_d(pd));

  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    r = prdata;
    // Slave never flags an error
    chk({31'h0, pslverr}, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // Drive pins, allow settling, then compare observation enables
  task automatic obs(input logic [3:0] req, input logic [3:0] exp);
    obs_req <= req;
    repeat (30) @(posedge pclk);
    chk({28'h0, obs_en}, {28'h0, exp});
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, sync_done, presetn} = 5'h0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    obs_req = 4'h0;
    tx_req  = 4'hA;
    rx_req  = 4'h6;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`RCM_OFF_TXCFG, 32'h0);
    wr(`RCM_OFF_TXCFG, 32'h0FF0);
    rd(`RCM_OFF_TXCFG, 32'h0);
    chk({20'h0, tx_en, rx_en, obs_en}, 32'h0);
    sync_done <= 1'b1;
    $display("test reset_and_sync done");
    // Transmit modes; pins are raised on channels 2 and 4 but must not matter
    wr(`RCM_OFF_TXCFG, 32'h0550);
    rd(`RCM_OFF_TXCFG, 32'h0511);
    chk({28'h0, tx_en}, 32'h5);
    wr(`RCM_OFF_TXCFG, 32'h00F1);
    rd(`RCM_OFF_TXCFG, 32'h0011);
    wr(`RCM_OFF_TXCFG, 32'h0F12);
    rd(`RCM_OFF_TXCFG, 32'h0F10);
    chk({28'h0, tx_en}, 32'h4);
    wr(`RCM_OFF_TXCFG, 32'h0FF0);
    rd(`RCM_OFF_TXCFG, 32'h0F55);
    chk({28'h0, tx_en}, 32'hF);
    $display("test transmit done");
    // Receive modes with pins raised on channels 2 and 3
    wr(`RCM_OFF_RXCFG, 32'h0031);
    rd(`RCM_OFF_RXCFG, 32'h000A);
    chk({28'h0, rx_en}, 32'h2);
    wr(`RCM_OFF_RXCFG, 32'h0C80);
    rd(`RCM_OFF_RXCFG, 32'h0C4A);
    wr(`RCM_OFF_RXCFG, 32'h0FF2);
    rd(`RCM_OFF_RXCFG, 32'h0F4A);
    chk({28'h0, rx_en}, 32'hA);
    $display("test receive done");
    // Observation: register control ignores the pins, then each pin mode decodes them
    wr(`RCM_OFF_ORXCFG, 32'h9000);
    obs(4'hF, 4'h9);
    wr(`RCM_OFF_ORXSEL, 32'h0002);
    wr(`RCM_OFF_ORXCFG, 32'h0003);
    obs(4'h1, 4'h4);
    wr(`RCM_OFF_ORXSEL, 32'h0004);
    rd(`RCM_OFF_ORXSEL, 32'h0002);
    obs(4'h0, 4'h0);
    obs(4'h1, 4'h4);
    wr(`RCM_OFF_ORXSEL, 32'h0310);
    wr(`RCM_OFF_ORXCFG, 32'h0002);
    obs(4'h1, 4'h2);
    obs(4'h3, 4'h8);
    obs(4'h2, 4'h0);
    wr(`RCM_OFF_ORXCFG, 32'h0001);
    for (int i = 0; i < 4; i++) begin
      obs({1'b0, i[1], i[0], 1'b1}, 4'h1 << i);
    end
    wr(`RCM_OFF_ORXCFG, 32'h0004);
    obs(4'h7, 4'h6);
    obs(4'hD, 4'h9);
    wr(`RCM_OFF_ORXSEL, 32'h1000);
    wr(`RCM_OFF_ORXCFG, 32'h0005);
    obs(4'h5, 4'h9);
    wr(`RCM_OFF_ORXCFG, 32'h0006);
    rd(`RCM_OFF_ORXCFG, 32'h0005);
    $display("test observe modes done");
    // Longest settling: pins seen two edges on, sampled 18 later, output one after
    wr(`RCM_OFF_ORXCFG, 32'h0103);
    obs(4'h0, 4'h0);
    obs_req <= 4'h1;
    repeat (20) @(posedge pclk);
    chk({28'h0, obs_en}, 32'h0);
    repeat (2) @(posedge pclk);
    chk({28'h0, obs_en}, 32'h1);
    rd(`RCM_OFF_STATUS, 32'h0022);
    $display("test settling done");
    tally_and_finish();
  end
endmodule // tb_top
